// file: eag_core.sv
// Purpose: Effective address generator: operand addresses and register updates.
// Assumes: The decoder holds request fields only in the cycle req_i is high.
// Notes: One request every two cycles; results show two cycles after the request.
// Contract
// - Seventeen registers, eight data, nine address; direct modes use actual contents.
// - Address register seven is supervisor stack when status supervisor bit set, else user.
// - Register indirect uses the selected address register unchanged as address.
// - Predecrement subtracts one, two or four, writes back, uses new value.
// - Postincrement uses old value, then adds one, two or four, writes back.
// - Displacement mode adds sign-extended 16-bit extension word to address register.
// - Index mode adds address register, sign-extended 8-bit displacement and index.
// - Index is any register; word size sign-extends low half, long uses all.
// - Special modes read the register field as a mode selector.
// - Absolute short is sign-extended 16 bits; absolute long is 32 bits.
// - Short form reaches only 0-7fff and ffff8000-ffffffff.
// - PC displacement adds sign-extended 16-bit displacement to program counter.
// - PC index adds program counter, sign-extended 8-bit displacement and index.
// - Immediate operands come from extension words for byte, word and long.
// - Branch target is program counter plus 8- or 16-bit displacement.
// - Implicit references reach active, supervisor, user stack or status word.
// - Odd addresses allowed only for byte accesses.
// - Program counter for relative modes is instruction address plus two.
`timescale 1ns/100ps
module eag_core (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Request from the decoder.
	input wire logic req_i,
	input wire logic [1:0] kind_i,
	input wire logic [2:0] mode_i,
	input wire logic [2:0] reg_sel_i,
	input wire logic [1:0] size_i,
	input wire logic [3:0] idx_sel_i,
	input wire logic idx_long_i,
	input wire logic br_long_i,
	input wire logic [1:0] implicit_i,
	input wire logic [15:0] ext0_i,
	input wire logic [15:0] ext1_i,
	input wire logic [31:0] pc_i,
	input wire logic [15:0] status_word_i,
	// Register load port.
	input wire logic wr_en_i,
	input wire logic [4:0] wr_slot_i,
	input wire logic [31:0] wr_data_i,
	// Results.
	output logic busy_o,
	output logic done_o,
	output logic [31:0] addr_o,
	output logic addr_valid_o,
	output logic [31:0] operand_o,
	output logic operand_valid_o,
	output logic in_reg_o,
	output logic odd_fault_o,
	output logic short_form_o,
	output logic reg_updated_o
);

	// Sign extension of a 16-bit field.
	function automatic logic [31:0] sext16(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	// Sign extension of an 8-bit field.
	function automatic logic [31:0] sext8(input logic [7:0] v);
		return {{24{v[7]}}, v};
	endfunction

	// Logical register to physical slot, folding the stack alias by state.
	function automatic logic [4:0] slot_of(input logic is_addr, input logic [2:0] num,
		input logic sup);
		logic [4:0] s;
		s = {2'h0, num};
		if (is_addr)
		begin
			if (num == eag_pkg::EAG_STACK_NUM)
				s = sup ? eag_pkg::EAG_SSP_SLOT : eag_pkg::EAG_USP_SLOT;
			else
				s = eag_pkg::EAG_ADDR_BASE + {2'h0, num};
		end
		return s;
	endfunction

	eag_pkg::eag_state_t state_r;
	eag_pkg::eag_state_t state_nxt;
	logic [1:0] kind_r;
	logic [2:0] mode_r;
	logic [2:0] reg_r;
	logic [1:0] size_r;
	logic idx_long_r;
	logic br_long_r;
	logic [1:0] impl_r;
	logic [15:0] ext0_r;
	logic [15:0] ext1_r;
	logic [31:0] pc_r;
	logic [15:0] sw_r;
	logic [4:0] ea_slot_r;
	logic [31:0] a_val;
	logic [31:0] b_val;
	logic [31:0] ix_val;
	logic [31:0] pc_base;
	logic [31:0] step;
	logic [31:0] imm_val;
	logic [31:0] addr_nxt;
	logic [31:0] operand_nxt;
	logic addr_valid_nxt;
	logic operand_valid_nxt;
	logic in_reg_nxt;
	logic wb_en;
	logic [31:0] wb_data;
	logic sup_now;
	logic take;
	logic calc;
	logic [4:0] ridx_a;
	logic [4:0] ridx_b;
	logic [4:0] bank_widx;
	logic [31:0] bank_wdata;
	logic bank_we;

	// Request acceptance and read indices taken straight from the request.
	assign take = req_i && (state_r == eag_pkg::EAG_IDLE);
	assign calc = (state_r == eag_pkg::EAG_CALC);
	assign sup_now = status_word_i[eag_pkg::EAG_SUPER_BIT];
	assign ridx_a = (kind_i != eag_pkg::EAG_K_IMPLICIT) ?
		slot_of(mode_i != eag_pkg::EAG_M_DATA, reg_sel_i, sup_now) :
		(implicit_i == eag_pkg::EAG_I_SSP) ? eag_pkg::EAG_SSP_SLOT :
		(implicit_i == eag_pkg::EAG_I_USP) ? eag_pkg::EAG_USP_SLOT :
		slot_of(1'b1, eag_pkg::EAG_STACK_NUM, sup_now);
	assign ridx_b = slot_of(idx_sel_i[3], idx_sel_i[2:0], sup_now);
	assign state_nxt = take ? eag_pkg::EAG_CALC : eag_pkg::EAG_IDLE;

	// Latch the request; the bank supplies register data one cycle later.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			state_r <= eag_pkg::EAG_IDLE;
			kind_r <= eag_pkg::EAG_K_EA;
			mode_r <= eag_pkg::EAG_M_DATA;
			reg_r <= 3'h0;
			size_r <= eag_pkg::EAG_SZ_BYTE;
			idx_long_r <= 1'b0;
			br_long_r <= 1'b0;
			impl_r <= eag_pkg::EAG_I_ACTIVE_SP;
			ext0_r <= 16'h0000;
			ext1_r <= 16'h0000;
			pc_r <= 32'h00000000;
			sw_r <= 16'h0000;
			ea_slot_r <= 5'h00;
		end
		else
		begin
			state_r <= state_nxt;
			if (take)
			begin
				kind_r <= kind_i;
				mode_r <= mode_i;
				reg_r <= reg_sel_i;
				size_r <= size_i;
				idx_long_r <= idx_long_i;
				br_long_r <= br_long_i;
				impl_r <= implicit_i;
				ext0_r <= ext0_i;
				ext1_r <= ext1_i;
				pc_r <= pc_i;
				sw_r <= status_word_i;
				ea_slot_r <= ridx_a;
			end
		end
	end

	// Operand arithmetic; plain 32-bit sums wrap without any carry flag.
	assign ix_val = idx_long_r ? b_val : sext16(b_val[15:0]);
	assign pc_base = pc_r + eag_pkg::EAG_PC_OFFSET;
	assign step = (size_r == eag_pkg::EAG_SZ_LONG) ? eag_pkg::EAG_STEP_LONG :
		(size_r == eag_pkg::EAG_SZ_WORD) ? eag_pkg::EAG_STEP_WORD :
		(reg_r == eag_pkg::EAG_STACK_NUM) ? eag_pkg::EAG_STEP_WORD :
		eag_pkg::EAG_STEP_BYTE;
	assign imm_val = (size_r == eag_pkg::EAG_SZ_LONG) ? {ext0_r, ext1_r} :
		(size_r == eag_pkg::EAG_SZ_WORD) ? {16'h0000, ext0_r} :
		{24'h000000, ext0_r[7:0]};

	// Mode selection of address, operand and write-back.
	always_comb
	begin
		addr_nxt = 32'h00000000;
		operand_nxt = 32'h00000000;
		addr_valid_nxt = 1'b0;
		operand_valid_nxt = 1'b0;
		in_reg_nxt = 1'b0;
		wb_en = 1'b0;
		wb_data = a_val;
		case (kind_r)
			eag_pkg::EAG_K_BRANCH:
			begin
				addr_nxt = pc_base + (br_long_r ? sext16(ext0_r) : sext8(ext0_r[7:0]));
				addr_valid_nxt = 1'b1;
			end
			eag_pkg::EAG_K_IMPLICIT:
			begin
				operand_nxt = (impl_r == eag_pkg::EAG_I_STATUS) ? {16'h0000, sw_r} : a_val;
				operand_valid_nxt = 1'b1;
				in_reg_nxt = 1'b1;
			end
			eag_pkg::EAG_K_EA:
			begin
				case (mode_r)
					eag_pkg::EAG_M_DATA, eag_pkg::EAG_M_ADDR:
					begin
						operand_nxt = a_val;
						operand_valid_nxt = 1'b1;
						in_reg_nxt = 1'b1;
					end
					eag_pkg::EAG_M_IND:
					begin
						addr_nxt = a_val;
						addr_valid_nxt = 1'b1;
					end
					eag_pkg::EAG_M_POSTINC:
					begin
						addr_nxt = a_val;
						addr_valid_nxt = 1'b1;
						wb_en = 1'b1;
						wb_data = a_val + step;
					end
					eag_pkg::EAG_M_PREDEC:
					begin
						addr_nxt = a_val - step;
						addr_valid_nxt = 1'b1;
						wb_en = 1'b1;
						wb_data = a_val - step;
					end
					eag_pkg::EAG_M_DISP:
					begin
						addr_nxt = a_val + sext16(ext0_r);
						addr_valid_nxt = 1'b1;
					end
					eag_pkg::EAG_M_INDEX:
					begin
						addr_nxt = a_val + sext8(ext0_r[7:0]) + ix_val;
						addr_valid_nxt = 1'b1;
					end
					eag_pkg::EAG_M_SPECIAL:
					begin
						case (reg_r)
							eag_pkg::EAG_S_ABS_SHORT:
							begin
								addr_nxt = sext16(ext0_r);
								addr_valid_nxt = 1'b1;
							end
							eag_pkg::EAG_S_ABS_LONG:
							begin
								addr_nxt = {ext0_r, ext1_r};
								addr_valid_nxt = 1'b1;
							end
							eag_pkg::EAG_S_PC_DISP:
							begin
								addr_nxt = pc_base + sext16(ext0_r);
								addr_valid_nxt = 1'b1;
							end
							eag_pkg::EAG_S_PC_INDEX:
							begin
								addr_nxt = pc_base + sext8(ext0_r[7:0]) + ix_val;
								addr_valid_nxt = 1'b1;
							end
							eag_pkg::EAG_S_IMM:
							begin
								operand_nxt = imm_val;
								operand_valid_nxt = 1'b1;
							end
							default:
							begin
								addr_valid_nxt = 1'b0;
							end
						endcase
					end
					default:
					begin
						addr_valid_nxt = 1'b0;
					end
				endcase
			end
			default:
			begin
				addr_valid_nxt = 1'b0;
			end
		endcase
	end

	// The bank write port: an address update outranks an outside load.
	assign bank_we = (calc && wb_en) || wr_en_i;
	assign bank_widx = (calc && wb_en) ? ea_slot_r : wr_slot_i;
	assign bank_wdata = (calc && wb_en) ? wb_data : wr_data_i;

	eag_regbank u_bank (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.we_i(bank_we),
		.widx_i(bank_widx),
		.wdata_i(bank_wdata),
		.ridx_a_i(ridx_a),
		.ridx_b_i(ridx_b),
		.rdata_a_o(a_val),
		.rdata_b_o(b_val)
	);

	// Result registers; busy_o, done_o and reg_updated_o update every cycle, the other outputs change only on the cycle after a calculation.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			addr_o <= 32'h00000000;
			addr_valid_o <= 1'b0;
			operand_o <= 32'h00000000;
			operand_valid_o <= 1'b0;
			in_reg_o <= 1'b0;
			odd_fault_o <= 1'b0;
			short_form_o <= 1'b0;
			reg_updated_o <= 1'b0;
		end
		else
		begin
			busy_o <= take;
			done_o <= calc;
			reg_updated_o <= calc && wb_en;
			if (calc)
			begin
				addr_o <= addr_nxt;
				addr_valid_o <= addr_valid_nxt;
				operand_o <= operand_nxt;
				operand_valid_o <= operand_valid_nxt;
				in_reg_o <= in_reg_nxt;
				odd_fault_o <= addr_valid_nxt && addr_nxt[0] &&
					(kind_r == eag_pkg::EAG_K_BRANCH || size_r != eag_pkg::EAG_SZ_BYTE);
				short_form_o <= addr_valid_nxt && ((addr_nxt <= eag_pkg::EAG_SHORT_LO_MAX) ||
					(addr_nxt >= eag_pkg::EAG_SHORT_HI_MIN));
			end
		end
	end

	// Checks on the generated results.
	chk_done_after_req: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		take |-> ##2 done_o) else $error("done missing two cycles after request");
	chk_ind_unchanged: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		calc && kind_r == eag_pkg::EAG_K_EA && mode_r == eag_pkg::EAG_M_IND
		|=> addr_o == $past(a_val) && !reg_updated_o) else $error("indirect address changed");
	chk_predec_addr: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		calc && kind_r == eag_pkg::EAG_K_EA && mode_r == eag_pkg::EAG_M_PREDEC
		|=> addr_o == $past(a_val) - $past(step) && reg_updated_o)
		else $error("predecrement address wrong");
	chk_postinc_wb: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		calc && kind_r == eag_pkg::EAG_K_EA && mode_r == eag_pkg::EAG_M_POSTINC
		|-> bank_we && bank_wdata == a_val + step ##1 addr_o == $past(a_val))
		else $error("postincrement update wrong");
	chk_stack_even: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		calc && wb_en && reg_r == eag_pkg::EAG_STACK_NUM && size_r == eag_pkg::EAG_SZ_BYTE
		|-> bank_we && bank_wdata[0] == a_val[0]) else $error("stack stepped by one");
	chk_disp_sum: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		calc && kind_r == eag_pkg::EAG_K_EA && mode_r == eag_pkg::EAG_M_DISP
		|=> addr_o == $past(a_val) + {{16{$past(ext0_r[15])}}, $past(ext0_r)})
		else $error("displacement sum wrong");
	chk_pc_base: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		take && kind_i == eag_pkg::EAG_K_BRANCH && !br_long_i && ext0_i[7:0] == 8'h00
		|-> ##2 addr_o == $past(pc_i, 2) + eag_pkg::EAG_PC_OFFSET)
		else $error("program counter base wrong");
	chk_odd_fault: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		done_o && addr_valid_o && addr_o[0] && $past(size_r) == eag_pkg::EAG_SZ_BYTE &&
		$past(kind_r) == eag_pkg::EAG_K_EA |-> !odd_fault_o)
		else $error("odd byte address flagged");
	chk_short_gap: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		done_o && addr_valid_o && addr_o > eag_pkg::EAG_SHORT_LO_MAX &&
		addr_o < eag_pkg::EAG_SHORT_HI_MIN |-> !short_form_o)
		else $error("short form claimed in gap");
	chk_busy_refuse: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		busy_o && req_i |=> !busy_o && done_o) else $error("request taken while busy");

	// Main scenarios.
	cov_predec: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		calc && mode_r == eag_pkg::EAG_M_PREDEC && kind_r == eag_pkg::EAG_K_EA);
	cov_pc_index: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		calc && mode_r == eag_pkg::EAG_M_SPECIAL && reg_r == eag_pkg::EAG_S_PC_INDEX);
	cov_branch: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		calc && kind_r == eag_pkg::EAG_K_BRANCH);
	cov_back_to_back: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		take ##2 take);

endmodule

// file: eag_pkg.sv
// Purpose: Shared constants and types for the effective address generator.
// Assumes: Codes for modes, kinds and sizes are the decoder's encoding.
// Notes: Physical register slots 0-7 hold data, 8-14 address 0-6, then two stacks.
package eag_pkg;

	// Word widths and register bank shape.
	localparam int EAG_XLEN = 32;
	localparam int EAG_NUM_REGS = 17;
	localparam int EAG_IDX_W = 5;

	// Physical slots of the register bank.
	localparam logic [4:0] EAG_ADDR_BASE = 5'h08;
	localparam logic [4:0] EAG_SSP_SLOT = 5'h0f;
	localparam logic [4:0] EAG_USP_SLOT = 5'h10;
	localparam logic [2:0] EAG_STACK_NUM = 3'h7;

	// Supervisor state bit of the status word.
	localparam int EAG_SUPER_BIT = 13;

	// Effective address mode field.
	localparam logic [2:0] EAG_M_DATA = 3'h0;
	localparam logic [2:0] EAG_M_ADDR = 3'h1;
	localparam logic [2:0] EAG_M_IND = 3'h2;
	localparam logic [2:0] EAG_M_POSTINC = 3'h3;
	localparam logic [2:0] EAG_M_PREDEC = 3'h4;
	localparam logic [2:0] EAG_M_DISP = 3'h5;
	localparam logic [2:0] EAG_M_INDEX = 3'h6;
	localparam logic [2:0] EAG_M_SPECIAL = 3'h7;

	// Register field selectors under the special mode.
	localparam logic [2:0] EAG_S_ABS_SHORT = 3'h0;
	localparam logic [2:0] EAG_S_ABS_LONG = 3'h1;
	localparam logic [2:0] EAG_S_PC_DISP = 3'h2;
	localparam logic [2:0] EAG_S_PC_INDEX = 3'h3;
	localparam logic [2:0] EAG_S_IMM = 3'h4;

	// Operand size codes.
	localparam logic [1:0] EAG_SZ_BYTE = 2'h0;
	localparam logic [1:0] EAG_SZ_WORD = 2'h1;
	localparam logic [1:0] EAG_SZ_LONG = 2'h2;

	// Request kinds.
	localparam logic [1:0] EAG_K_EA = 2'h0;
	localparam logic [1:0] EAG_K_BRANCH = 2'h1;
	localparam logic [1:0] EAG_K_IMPLICIT = 2'h2;

	// Implicit reference selectors.
	localparam logic [1:0] EAG_I_ACTIVE_SP = 2'h0;
	localparam logic [1:0] EAG_I_SSP = 2'h1;
	localparam logic [1:0] EAG_I_USP = 2'h2;
	localparam logic [1:0] EAG_I_STATUS = 2'h3;

	// Steps, program counter offset and absolute short reach.
	localparam logic [31:0] EAG_STEP_BYTE = 32'h00000001;
	localparam logic [31:0] EAG_STEP_WORD = 32'h00000002;
	localparam logic [31:0] EAG_STEP_LONG = 32'h00000004;
	localparam logic [31:0] EAG_PC_OFFSET = 32'h00000002;
	localparam logic [31:0] EAG_SHORT_LO_MAX = 32'h00007fff;
	localparam logic [31:0] EAG_SHORT_HI_MIN = 32'hffff8000;

	typedef enum logic {EAG_IDLE, EAG_CALC} eag_state_t;

endpackage

// file: eag_regbank.sv
// Purpose: Bank of seventeen 32-bit registers with two registered read ports.
// Assumes: One write port; a write and a read of one slot in a cycle reads old data.
// Notes: Read data appear one clock after the index is presented.
`timescale 1ns/100ps
module eag_regbank #(
	parameter int WIDTH = eag_pkg::EAG_XLEN,
	parameter int DEPTH = eag_pkg::EAG_NUM_REGS,
	parameter int IDX_W = eag_pkg::EAG_IDX_W
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Write port.
	input wire logic we_i,
	input wire logic [IDX_W-1:0] widx_i,
	input wire logic [WIDTH-1:0] wdata_i,
	// Read ports.
	input wire logic [IDX_W-1:0] ridx_a_i,
	input wire logic [IDX_W-1:0] ridx_b_i,
	output logic [WIDTH-1:0] rdata_a_o,
	output logic [WIDTH-1:0] rdata_b_o
);

	logic [WIDTH-1:0] mem_r [DEPTH];

	// Storage; registers clear on reset so reads never return unknowns.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= '0;
		end
		else if (we_i && (int'(widx_i) < DEPTH))
			mem_r[widx_i] <= wdata_i;
	end

	// Registered reads; an out-of-range index reads zero.
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			rdata_a_o <= '0;
			rdata_b_o <= '0;
		end
		else
		begin
			rdata_a_o <= (int'(ridx_a_i) < DEPTH) ? mem_r[ridx_a_i] : '0;
			rdata_b_o <= (int'(ridx_b_i) < DEPTH) ? mem_r[ridx_b_i] : '0;
		end
	end

endmodule

// file: eag_regfile_model.sv
// Purpose: Register file side model that loads the core's bank through its load port.
// Assumes: Loads are driven at the falling edge and stored at the next rising edge.
// Notes: Keeps a mirror of every slot for the bench's reference model.
`timescale 1ns/100ps
module eag_regfile_model (
	// Clock.
	input wire logic sys_clk_i,
	// Load port toward the core.
	output logic wr_en_o,
	output logic [4:0] wr_slot_o,
	output logic [31:0] wr_data_o
);
	// Mirror of the seventeen slots, all cleared like the bank after reset.
	logic [31:0] mirror [0:16];

	// Idle load port at time zero.
	initial
	begin
		wr_en_o = 1'b0;
		wr_slot_o = 5'h00;
		wr_data_o = 32'h00000000;
		foreach (mirror[i]) mirror[i] = 32'h00000000;
	end

	// One load per call; released data is inverted so no stale value can pass for a load.
	task automatic load(input logic [4:0] slot, input logic [31:0] data);
		@(negedge sys_clk_i);
		wr_en_o = 1'b1;
		wr_slot_o = slot;
		wr_data_o = data;
		@(negedge sys_clk_i);
		wr_en_o = 1'b0;
		wr_data_o = ~data;
		mirror[slot] = data;
	endtask
endmodule

// file: effective_address_generator_tb.sv
// Purpose: Self-checking bench for the effective address generator core.
// Assumes: Inputs change at the falling edge; one request at a time.
// Notes: A reference model predicts every result from the mirrored registers.
`timescale 1ns/100ps
module effective_address_generator_tb;
	// Stimulus and observed signals.
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic req_i = 1'b0, idx_long_i = 1'b0, br_long_i = 1'b0;
	logic [1:0] kind_i = 2'h0, size_i = 2'h0, implicit_i = 2'h0;
	logic [2:0] mode_i = 3'h0, reg_sel_i = 3'h0;
	logic [3:0] idx_sel_i = 4'h0;
	logic [15:0] ext0_i = 16'h0000, ext1_i = 16'h0000, status_word_i = 16'h0000;
	logic [31:0] pc_i = 32'h00000000;
	logic wr_en_i;
	logic [4:0] wr_slot_i;
	logic [31:0] wr_data_i, addr_o, operand_o;
	logic busy_o, done_o, addr_valid_o, operand_valid_o, in_reg_o;
	logic odd_fault_o, short_form_o, reg_updated_o;
	logic [31:0] bnd [0:3] = '{32'h00007fff, 32'h00008000, 32'hffff7fff, 32'hffff8000};
	int n_errors = 0;
	int n_compared = 0;
	integer seed = 32'h229069e5;

	// Clock at 40 MHz.
	always #12.5 sys_clk_i = ~sys_clk_i;

	// Device under test and the register file side.
	eag_core u_eag_core (.sys_clk_i, .reset_i, .req_i, .kind_i, .mode_i, .reg_sel_i,
		.size_i, .idx_sel_i, .idx_long_i, .br_long_i, .implicit_i, .ext0_i, .ext1_i,
		.pc_i, .status_word_i, .wr_en_i, .wr_slot_i, .wr_data_i, .busy_o, .done_o,
		.addr_o, .addr_valid_o, .operand_o, .operand_valid_o, .in_reg_o,
		.odd_fault_o, .short_form_o, .reg_updated_o);
	eag_regfile_model u_eag_regfile_model (.sys_clk_i, .wr_en_o(wr_en_i),
		.wr_slot_o(wr_slot_i), .wr_data_o(wr_data_i));

	// Comparison, test summary and verdict.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_test(input string name);
		$display("test %s ended, mismatches so far %0d", name, n_errors);
	endtask
	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Sign extension helpers of the reference model.
	function automatic logic [31:0] sx16(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction
	function automatic logic [31:0] sx8(input logic [7:0] v);
		return {{24{v[7]}}, v};
	endfunction

	// Register number to physical slot; number seven of the address bank follows the mode.
	function automatic logic [4:0] slot_of(input logic bank, input logic [2:0] n);
		if (!bank)
			return {2'b00, n};
		if (n != eag_pkg::EAG_STACK_NUM)
			return eag_pkg::EAG_ADDR_BASE + {2'b00, n};
		if (status_word_i[eag_pkg::EAG_SUPER_BIT])
			return eag_pkg::EAG_SSP_SLOT;
		return eag_pkg::EAG_USP_SLOT;
	endfunction

	// Random request fields, kept inside the encodings the core accepts.
	task automatic shake();
		kind_i = 2'($unsigned($random(seed)) % 3);
		mode_i = 3'($random(seed));
		reg_sel_i = 3'($random(seed));
		size_i = 2'($unsigned($random(seed)) % 3);
		idx_sel_i = 4'($random(seed));
		{idx_long_i, br_long_i, implicit_i} = 4'($random(seed));
		{ext0_i, ext1_i} = $random(seed);
		pc_i = $random(seed);
		status_word_i = 16'($random(seed));
	endtask

	// One request: predict, present, check the answer two edges after it is taken.
	task automatic run(input logic hold);
		logic [31:0] a, idx, ea, op, step;
		logic [4:0] s, s2;
		logic sp, av, ov, ir, wb;
		@(negedge sys_clk_i);
		s = slot_of(1'b1, reg_sel_i);
		a = u_eag_regfile_model.mirror[s];
		idx = u_eag_regfile_model.mirror[slot_of(idx_sel_i[3], idx_sel_i[2:0])];
		idx = idx_long_i ? idx : sx16(idx[15:0]);
		step = size_i == 2'h2 ? 32'h4 : (size_i == 2'h1 || reg_sel_i == 3'h7) ? 32'h2 : 32'h1;
		sp = kind_i == 2'h0 && mode_i == 3'h7;
		av = kind_i == 2'h1 || (kind_i == 2'h0 && mode_i inside {[3'h2:3'h6]});
		av = av || (sp && reg_sel_i < 3'h4);
		ir = kind_i == 2'h2 || (kind_i == 2'h0 && mode_i < 3'h2);
		ov = ir || (sp && reg_sel_i == 3'h4);
		wb = kind_i == 2'h0 && mode_i inside {3'h3, 3'h4};
		case (mode_i)
			3'h4: ea = a - step;
			3'h5: ea = a + sx16(ext0_i);
			3'h6: ea = a + sx8(ext0_i[7:0]) + idx;
			default: ea = a;
		endcase
		if (sp)
		begin
			case (reg_sel_i)
				3'h0: ea = sx16(ext0_i);
				3'h1: ea = {ext0_i, ext1_i};
				3'h2: ea = pc_i + 32'h2 + sx16(ext0_i);
				default: ea = pc_i + 32'h2 + sx8(ext0_i[7:0]) + idx;
			endcase
		end
		if (kind_i == 2'h1)
			ea = pc_i + 32'h2 + (br_long_i ? sx16(ext0_i) : sx8(ext0_i[7:0]));
		op = mode_i == 3'h0 ? u_eag_regfile_model.mirror[{2'b00, reg_sel_i}] : a;
		if (sp)
			op = size_i == 2'h0 ? {24'h000000, ext0_i[7:0]} : {16'h0000, ext0_i};
		if (sp && size_i == 2'h2)
			op = {ext0_i, ext1_i};
		s2 = implicit_i == 2'h1 ? eag_pkg::EAG_SSP_SLOT : eag_pkg::EAG_USP_SLOT;
		s2 = implicit_i == 2'h0 ? slot_of(1'b1, 3'h7) : s2;
		if (kind_i == 2'h2)
			op = implicit_i == 2'h3 ? {16'h0000, status_word_i} : u_eag_regfile_model.mirror[s2];
		req_i = 1'b1;
		@(negedge sys_clk_i);
		req_i = hold;
		check(busy_o, 1'b1);
		@(negedge sys_clk_i);
		req_i = 1'b0;
		check(done_o, 1'b1);
		check(reg_updated_o, wb);
		check(addr_valid_o, av);
		check(operand_valid_o, ov);
		check(in_reg_o, ir);
		if (ov)
			check(operand_o, op);
		else
			check(operand_o, 32'h00000000);
		if (av)
		begin
			check(addr_o, ea);
			check(odd_fault_o, ea[0] && (size_i != 2'h0 || kind_i == 2'h1));
			check(short_form_o, ea < 32'h00008000 || ea >= 32'hffff8000);
		end
		else
			check(addr_o, 32'h00000000);
		if (wb)
			u_eag_regfile_model.mirror[s] = mode_i == 3'h4 ? ea : a + step;
		for (int k = 0; k < 2 && hold; k++)
		begin
			@(negedge sys_clk_i);
			check(done_o, 1'b0);
			check(busy_o, 1'b0);
		end
	endtask

	// Watchdog sized well above the roughly 1300 cycles the tests need.
	initial
	begin
		#(25 * 40000);
		n_errors++;
		$display("BAD t=%0t watchdog expired", $time);
		close_out();
	end

	// Main sequence.
	initial
	begin
		repeat (16) @(negedge sys_clk_i);
		check(addr_o, 32'h00000000);
		check(operand_o, 32'h00000000);
		check({busy_o, done_o, addr_valid_o, operand_valid_o, in_reg_o}, 32'h00000000);
		reset_i = 1'b0;
		reg_sel_i = 3'h3;
		run(1'b0);
		end_test("reset");
		for (int i = 0; i < 17; i++)
			u_eag_regfile_model.load(5'(i), $random(seed));
		for (int i = 0; i < 64; i++)
		begin
			shake();
			kind_i = 2'h0;
			{mode_i, reg_sel_i} = 6'(i);
			run(1'b0);
		end
		end_test("modes");
		for (int i = 0; i < 12; i++)
		begin
			shake();
			kind_i = i < 4 ? 2'h1 : 2'h2;
			{status_word_i[13], implicit_i} = 3'(i);
			br_long_i = i[0];
			// A zero short displacement makes the target the bare base address.
			if (i == 0)
				ext0_i[7:0] = 8'h00;
			run(1'b0);
		end
		end_test("branch and implicit");
		for (int i = 0; i < 8; i++)
		begin
			{kind_i, mode_i, reg_sel_i, size_i} = {2'h0, 3'h7, 2'b00, i[2], 2'h2};
			ext0_i = i[2] ? bnd[i[1:0]][31:16] : bnd[i[1:0]][15:0];
			ext1_i = bnd[i[1:0]][15:0];
			run(1'b0);
		end
		end_test("absolute reach");
		u_eag_regfile_model.load(5'h08, 32'h00000002);
		for (int i = 0; i < 5; i++)
		begin
			shake();
			kind_i = 2'h0;
			mode_i = (i == 0 || i == 4) ? 3'h4 : (i == 2) ? 3'h2 : 3'h3;
			reg_sel_i = i < 3 ? 3'h0 : 3'h7;
			size_i = i < 3 ? 2'h2 : 2'h0;
			status_word_i[13] = i[0];
			run(i == 1);
		end
		end_test("wrap, refusal and stack step");
		for (int i = 0; i < 300; i++)
		begin
			if (i % 16 == 0)
				u_eag_regfile_model.load(5'($unsigned($random(seed)) % 17), $random(seed));
			shake();
			run(1'b0);
		end
		end_test("random");
		close_out();
	end
endmodule
